/* hdl/pcim_pkg.sv */
// pcim_pkg: constants and types of the pin control and interrupt mux block.
// assumes a 32-bit register port with byte addresses and one 40 MHz clock.
package pcim_pkg;

  // register port geometry
  localparam int          PCIM_AW          = 12;
  localparam int          PCIM_DW          = 32;
  localparam int          PCIM_NIRQ        = 2;           // pins that can trigger
  localparam int          PCIM_NSYNC       = 2;           // synchroniser depth

  // register byte offsets
  localparam logic [11:0] OFF_PIN25_CTL    = 12'h070;
  localparam logic [11:0] OFF_PIN26_CTL    = 12'h074;
  localparam logic [11:0] OFF_PIN38_CTL    = 12'h0A4;
  localparam logic [11:0] OFF_IRQ_STATUS   = 12'h100;     // read only, sticky pending
  localparam logic [11:0] OFF_IRQ_CLEAR    = 12'h104;     // write only, one clears
  localparam logic [11:0] OFF_IRQ_ENABLE   = 12'h108;     // gates IRQ_O

  // writable bit masks and reset values
  localparam logic [31:0] MASK_TRIG_PIN    = 32'h02F0_7BFF;
  localparam logic [31:0] MASK_PIN38       = 32'h0000_73D0;
  localparam logic [31:0] RST_TRIG_PIN     = 32'h0000_1001;
  localparam logic [31:0] RST_PIN38        = 32'h0000_1010;
  localparam logic [31:0] MASK_IRQ         = 32'h0000_0003;

  // field positions
  localparam int          B_FWD_MASK       = 25;
  localparam int          B_TRIG_HI        = 23;
  localparam int          B_TRIG_LO        = 21;
  localparam int          B_IRQ_EN         = 20;
  localparam int          B_DRV_HI         = 14;
  localparam int          B_DRV_LO         = 12;
  localparam int          B_STRONG_PU      = 11;
  localparam int          B_WEAK_PD        = 9;
  localparam int          B_PU             = 8;
  localparam int          B_IN_EN          = 7;
  localparam int          B_OUT_EN         = 6;
  localparam int          B_HYST           = 5;
  localparam int          B_ANALOG         = 4;
  localparam int          B_FUNC_HI        = 3;
  localparam int          B_FUNC_LO        = 0;

  // trigger select codes
  localparam logic [2:0]  TRIG_RISE        = 3'h0;
  localparam logic [2:0]  TRIG_FALL        = 3'h1;
  localparam logic [2:0]  TRIG_BOTH        = 3'h2;
  localparam logic [2:0]  TRIG_HIGH        = 3'h3;
  localparam logic [2:0]  TRIG_LOW         = 3'h4;

  // drive level after reset
  localparam logic [2:0]  DRV_RST          = 3'h1;

  // function select codes
  localparam logic [3:0]  FN_LCD_SEG       = 4'h0;
  localparam logic [3:0]  FN_PLAIN         = 4'h1;
  localparam logic [3:0]  FN_AUDIO_MCLK    = 4'h6;
  localparam logic [3:0]  FN_SERIAL        = 4'h8;

  // pad configuration toward one pad
  typedef struct packed {
    logic [2:0] drive_strength;
    logic       strong_pullup_en;
    logic       weak_pulldown_en;
    logic       mid_pullup_en;
    logic       weak_pullup_en;
    logic       input_buffer_en;
    logic       output_driver_en;
    logic       hysteresis_en;
    logic       analog_sel;
  } pcim_pad_t;

  // register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pcim_req_t;

endpackage : pcim_pkg

/* hdl/pcim_trig_det.sv */
// pcim_trig_det: synchronises one pin input and detects the selected trigger.
// assumes the pin level is asynchronous; event is a combinational level.
`timescale 1ns/10ps
module pcim_trig_det
  import pcim_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // pin and mode
  input  wire logic       pin_i,
  input  wire logic [2:0] mode_i,
  // detected event, one per cycle it holds
  output logic            event_o
);

  logic sync1_ff, sync2_ff, prev_ff;          // two-stage synchroniser and last sample
  logic nxt_sync1, nxt_sync2, nxt_prev;

  // next values of the sample chain
  always_comb begin
    nxt_sync1 = pin_i;
    nxt_sync2 = sync1_ff;
    nxt_prev  = sync2_ff;
  end

  // sample chain registers; sync1 only feeds sync2
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff  <= nxt_prev;
    end
  end

  // edge modes compare two samples, level modes look at the current one
  always_comb begin
    case (mode_i)
      TRIG_RISE: event_o = sync2_ff & ~prev_ff;
      TRIG_FALL: event_o = ~sync2_ff & prev_ff;
      TRIG_BOTH: event_o = sync2_ff ^ prev_ff;
      TRIG_HIGH: event_o = sync2_ff;
      TRIG_LOW:  event_o = ~sync2_ff;
      default:   event_o = 1'b0;                      // reserved codes detect nothing
    endcase
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_rise_edge: assert property ((mode_i == TRIG_RISE) && $rose(sync2_ff) |-> event_o)
    else $error("rising edge not detected");
  a_level_cause: assert property (event_o && (mode_i == TRIG_LOW) |-> !sync2_ff)
    else $error("low level event without low input");
  a_sync_delay: assert property ($rose(pin_i) ##1 pin_i ##1 pin_i |-> sync2_ff)
    else $error("synchroniser slower than two cycles");

endmodule : pcim_trig_det

/* hdl/pcim_top.sv */
// pcim_top: control registers for pins 25, 26, 38; pending flags and interrupt forwarding for 25 and 26.
// assumes a register port master with one-cycle strobes, port inputs synchronous to CLK_I; PIN_I is synchronised here.
// assumes pin 38 needs no trigger logic, so its pad level is not watched here.
// assumes software claims each converter channel for one pin at a time.
// Behaviour
// - trigger field selects rise, fall, both, high, low
// - interrupt enable gates pending and requests
// - forward request only when enable and mask
// - drive field picks eight levels, resets 001
// - bit 11 enables strong pull-up, pins 25/26
// - bit 9 enables weak pull-down, all pins
// - bit 8 enables pull-up, mid or weak
// - bit 7 input buffer, bit 6 output driver
// - bit 5 hysteresis on 25/26, zero on 38
// - bit 4 routes pin to converter channel
// - function field picks peripheral, reset plain pin
// - pin 38 bit 4 selects reference output
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
module pcim_top
  import pcim_pkg::*;
(
  // clock and reset
  input  wire logic                   CLK_I,
  input  wire logic                   RST_B_I,
  // register port
  input  wire logic [PCIM_AW-1:0]     ADDR_I,
  input  wire logic [PCIM_DW-1:0]     WR_DATA_I,
  input  wire logic                   WR_I,
  input  wire logic                   RD_I,
  output logic      [PCIM_DW-1:0]     RD_DATA_O,
  // pin levels of 25 and 26
  input  wire logic [PCIM_NIRQ-1:0]   PIN_I,
  // pad configuration
  output pcim_pkg::pcim_pad_t         PAD25_O,
  output pcim_pkg::pcim_pad_t         PAD26_O,
  output pcim_pkg::pcim_pad_t         PAD38_O,
  // function and analog routing
  output logic      [3:0]             FUNC25_SEL_O,
  output logic      [3:0]             FUNC26_SEL_O,
  output logic                        ADC9_SEL_O,
  output logic                        ADC10_SEL_O,
  output logic                        VREF_OUT_EN_O,
  // interrupt side
  output logic      [PCIM_NIRQ-1:0]   PEND_O,
  output logic      [PCIM_NIRQ-1:0]   INTERRUPT_CONTROLLER_REQ_O,
  output logic                        IRQ_O
);

  // effective function code: reserved codes fall back to the plain pin
  function automatic logic [3:0] fn_effective(input logic [3:0] code, input logic has_mclk);
    logic [3:0] res;
    res = code;
    if (code > FN_SERIAL) begin
      res = FN_PLAIN;
    end else if ((code == FN_AUDIO_MCLK) && !has_mclk) begin
      res = FN_PLAIN;
    end
    return res;
  endfunction : fn_effective

  logic [31:0]           ctl_ff [PCIM_NIRQ];   // control of pins 25 and 26
  logic [31:0]           nxt_ctl [PCIM_NIRQ];
  logic [31:0]           ctl38_ff;             // control of pin 38
  logic [31:0]           nxt_ctl38;
  logic [PCIM_NIRQ-1:0]  pend_ff;              // sticky pending flags
  logic [PCIM_NIRQ-1:0]  nxt_pend;
  logic [PCIM_NIRQ-1:0]  irq_en_ff;            // enable for IRQ_O
  logic [PCIM_NIRQ-1:0]  nxt_irq_en;
  logic [31:0]           rdata_ff;             // read data, valid one cycle
  logic [31:0]           nxt_rdata;
  logic [PCIM_NIRQ-1:0]  evt;                  // detected trigger events
  logic [PCIM_NIRQ-1:0]  clr;                  // clear strobes from software
  pcim_req_t             req;                  // bundled register request

  // bundle the port into one carrier so every decode reads the same fields
  assign req = '{addr: ADDR_I, wdata: WR_DATA_I, wr: WR_I, rd: RD_I};

  // one detector per triggering pin
  for (genvar g = 0; g < PCIM_NIRQ; g++) begin : g_det
    pcim_trig_det u_det (
      .clk_i   (CLK_I),
      .rst_b_i (RST_B_I),
      .pin_i   (PIN_I[g]),
      .mode_i  (ctl_ff[g][B_TRIG_HI:B_TRIG_LO]),
      .event_o (evt[g])
    );
  end

  // register writes; reserved bits are masked away
  always_comb begin
    nxt_ctl[0] = ctl_ff[0];
    nxt_ctl[1] = ctl_ff[1];
    nxt_ctl38  = ctl38_ff;
    nxt_irq_en = irq_en_ff;
    clr        = '0;
    // one write lands per strobe; unmapped addresses fall through untouched
    if (req.wr) begin
      if (req.addr == OFF_PIN25_CTL) begin
        nxt_ctl[0] = req.wdata & MASK_TRIG_PIN;
      end else if (req.addr == OFF_PIN26_CTL) begin
        nxt_ctl[1] = req.wdata & MASK_TRIG_PIN;
      end else if (req.addr == OFF_PIN38_CTL) begin
        nxt_ctl38 = req.wdata & MASK_PIN38;
      end else if (req.addr == OFF_IRQ_CLEAR) begin
        clr = req.wdata[PCIM_NIRQ-1:0];
      end else if (req.addr == OFF_IRQ_ENABLE) begin
        nxt_irq_en = req.wdata[PCIM_NIRQ-1:0];
      end
    end
  end

  // control registers
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      ctl_ff[0] <= RST_TRIG_PIN;
      ctl_ff[1] <= RST_TRIG_PIN;
      ctl38_ff  <= RST_PIN38;
      irq_en_ff <= '0;
    end else begin
      ctl_ff[0] <= nxt_ctl[0];
      ctl_ff[1] <= nxt_ctl[1];
      ctl38_ff  <= nxt_ctl38;
      irq_en_ff <= nxt_irq_en;
    end
  end

  // reserved trigger codes give no event, so pending simply holds
  // pending flags: set only while enabled, set wins over clear
  always_comb begin
    for (int i = 0; i < PCIM_NIRQ; i++) begin
      nxt_pend[i] = (pend_ff[i] & ~clr[i]) | (evt[i] & ctl_ff[i][B_IRQ_EN]);
    end
  end

  // pending registers
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // read data mux, zero outside the read-data cycle and for unmapped addresses
  always_comb begin
    // clear register and unmapped places read as zero
    nxt_rdata = '0;
    if (req.rd) begin
      if (req.addr == OFF_PIN25_CTL) begin
        nxt_rdata = ctl_ff[0];
      end else if (req.addr == OFF_PIN26_CTL) begin
        nxt_rdata = ctl_ff[1];
      end else if (req.addr == OFF_PIN38_CTL) begin
        nxt_rdata = ctl38_ff;
      end else if (req.addr == OFF_IRQ_STATUS) begin
        nxt_rdata = {{(PCIM_DW-PCIM_NIRQ){1'h0}}, pend_ff};
      end else if (req.addr == OFF_IRQ_ENABLE) begin
        nxt_rdata = {{(PCIM_DW-PCIM_NIRQ){1'h0}}, irq_en_ff};
      end
    end
  end

  // read data register
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign RD_DATA_O = rdata_ff;

  // pad fields of pins 25, 26 and 38
  always_comb begin
    // pin 25 routes bit 8 to the mid pull-up
    PAD25_O = '{drive_strength:   ctl_ff[0][B_DRV_HI:B_DRV_LO],
                strong_pullup_en: ctl_ff[0][B_STRONG_PU],
                weak_pulldown_en: ctl_ff[0][B_WEAK_PD],
                mid_pullup_en:    ctl_ff[0][B_PU],
                weak_pullup_en:   1'b0,
                input_buffer_en:  ctl_ff[0][B_IN_EN],
                output_driver_en: ctl_ff[0][B_OUT_EN],
                hysteresis_en:    ctl_ff[0][B_HYST],
                analog_sel:       ctl_ff[0][B_ANALOG]};
    // pin 26 routes bit 8 to the weak pull-up
    PAD26_O = '{drive_strength:   ctl_ff[1][B_DRV_HI:B_DRV_LO],
                strong_pullup_en: ctl_ff[1][B_STRONG_PU],
                weak_pulldown_en: ctl_ff[1][B_WEAK_PD],
                mid_pullup_en:    1'b0,
                weak_pullup_en:   ctl_ff[1][B_PU],
                input_buffer_en:  ctl_ff[1][B_IN_EN],
                output_driver_en: ctl_ff[1][B_OUT_EN],
                hysteresis_en:    ctl_ff[1][B_HYST],
                analog_sel:       ctl_ff[1][B_ANALOG]};
    // pin 38 has no strong pull-up and no hysteresis
    PAD38_O = '{drive_strength:   ctl38_ff[B_DRV_HI:B_DRV_LO],
                strong_pullup_en: 1'b0,
                weak_pulldown_en: ctl38_ff[B_WEAK_PD],
                mid_pullup_en:    1'b0,
                weak_pullup_en:   ctl38_ff[B_PU],
                input_buffer_en:  ctl38_ff[B_IN_EN],
                output_driver_en: ctl38_ff[B_OUT_EN],
                hysteresis_en:    1'b0,
                analog_sel:       ctl38_ff[B_ANALOG]};
  end

  // function mux selects; analog select drives the converter lines and leaves the function code as it is
  assign FUNC25_SEL_O  = fn_effective(ctl_ff[0][B_FUNC_HI:B_FUNC_LO], 1'b1);
  assign FUNC26_SEL_O  = fn_effective(ctl_ff[1][B_FUNC_HI:B_FUNC_LO], 1'b0);
  assign ADC9_SEL_O    = ctl_ff[0][B_ANALOG];
  assign ADC10_SEL_O   = ctl_ff[1][B_ANALOG];
  assign VREF_OUT_EN_O = ctl38_ff[B_ANALOG];

  // interrupt outputs
  always_comb begin
    for (int i = 0; i < PCIM_NIRQ; i++) begin
      // a request needs pending, enable and forward mask together
      INTERRUPT_CONTROLLER_REQ_O[i] = pend_ff[i] & ctl_ff[i][B_IRQ_EN] & ctl_ff[i][B_FWD_MASK];
    end
  end
  assign PEND_O = pend_ff;
  assign IRQ_O  = |(pend_ff & irq_en_ff);

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_pend_needs_en: assert property ($rose(pend_ff[0]) |-> $past(ctl_ff[0][B_IRQ_EN]))
    else $error("pending set while interrupt disabled");
  a_pend_on_evt: assert property (evt[1] && ctl_ff[1][B_IRQ_EN] |=> pend_ff[1])
    else $error("enabled event did not set pending");
  a_fwd_gated: assert property (INTERRUPT_CONTROLLER_REQ_O[0] |-> ctl_ff[0][B_FWD_MASK] && pend_ff[0])
    else $error("request forwarded while masked");
  a_drive_reset: assert property ($past(!RST_B_I) |-> PAD26_O.drive_strength == DRV_RST)
    else $error("drive level wrong after reset");
  a_func_reset: assert property ($past(!RST_B_I) |-> FUNC25_SEL_O == FN_PLAIN)
    else $error("function not plain after reset");
  a_ref_reset: assert property ($past(!RST_B_I) |-> VREF_OUT_EN_O ##1 VREF_OUT_EN_O)
    else $error("reference output not selected after reset");
  a_analog_wr: assert property (WR_I && ADDR_I == OFF_PIN25_CTL |=> ADC9_SEL_O == $past(WR_DATA_I[B_ANALOG]))
    else $error("analog select write not applied");
  a_rsv_zero: assert property (RD_I && ADDR_I == OFF_PIN38_CTL |=> (RD_DATA_O & ~MASK_PIN38) == '0)
    else $error("reserved bits read non-zero");
  a_hyst_38: assert property (WR_I && ADDR_I == OFF_PIN38_CTL |=> !PAD38_O.hysteresis_en)
    else $error("pin 38 hysteresis set");
  a_set_wins: assert property (evt[0] && ctl_ff[0][B_IRQ_EN] && clr[0] |=> pend_ff[0])
    else $error("event lost against clear");
  a_rd_once: assert property (!RD_I |=> RD_DATA_O == '0)
    else $error("read data outside its cycle");

  // pad fields and analog selects follow the last accepted write of their pin; reserved bits stay clear
  a_drive_wr: assert property (WR_I && ADDR_I == OFF_PIN38_CTL
    |=> PAD38_O.drive_strength == $past(WR_DATA_I[B_DRV_HI:B_DRV_LO]))
    else $error("drive level not taken from write");
  a_strong_pu_wr: assert property (WR_I && ADDR_I == OFF_PIN25_CTL
    |=> PAD25_O.strong_pullup_en == $past(WR_DATA_I[B_STRONG_PU]))
    else $error("strong pull-up not taken from write");
  a_pulldown_wr: assert property (WR_I && ADDR_I == OFF_PIN38_CTL
    |=> PAD38_O.weak_pulldown_en == $past(WR_DATA_I[B_WEAK_PD]))
    else $error("pull-down not taken from write");
  a_pullup_route: assert property (WR_I && ADDR_I == OFF_PIN26_CTL
    |=> PAD26_O.weak_pullup_en == $past(WR_DATA_I[B_PU]) && !PAD26_O.mid_pullup_en)
    else $error("pin 26 pull-up routed wrongly");
  a_buffers_wr: assert property (WR_I && ADDR_I == OFF_PIN26_CTL
    |=> PAD26_O.input_buffer_en == $past(WR_DATA_I[B_IN_EN])
        && PAD26_O.output_driver_en == $past(WR_DATA_I[B_OUT_EN]))
    else $error("buffer enables not taken from write");
  a_hyst_wr: assert property (WR_I && ADDR_I == OFF_PIN25_CTL
    |=> PAD25_O.hysteresis_en == $past(WR_DATA_I[B_HYST]))
    else $error("pin 25 hysteresis not taken from write");
  a_adc10_wr: assert property (WR_I && ADDR_I == OFF_PIN26_CTL
    |=> ADC10_SEL_O == $past(WR_DATA_I[B_ANALOG]))
    else $error("converter select of pin 26 not applied");
  a_vref_wr: assert property (WR_I && ADDR_I == OFF_PIN38_CTL
    |=> VREF_OUT_EN_O == $past(WR_DATA_I[B_ANALOG]))
    else $error("reference output select not applied");
  a_ctl_masked: assert property (WR_I && ADDR_I == OFF_PIN25_CTL
    |=> (ctl_ff[0] & ~MASK_TRIG_PIN) == '0)
    else $error("reserved control bits stored");

  // reserved function codes and interrupt gating
  a_fn_rsv_26: assert property (ctl_ff[1][B_FUNC_HI:B_FUNC_LO] == FN_AUDIO_MCLK
    |-> FUNC26_SEL_O == FN_PLAIN)
    else $error("reserved pin 26 code reached the mux");
  a_mask_blocks: assert property (!ctl_ff[1][B_FWD_MASK] |-> !INTERRUPT_CONTROLLER_REQ_O[1])
    else $error("masked request forwarded");
  a_fwd_on_pend: assert property (pend_ff[0] && ctl_ff[0][B_FWD_MASK]
    && ctl_ff[0][B_IRQ_EN] |-> INTERRUPT_CONTROLLER_REQ_O[0])
    else $error("enabled request not forwarded");
  a_en_blocks: assert property (!ctl_ff[1][B_IRQ_EN] && !pend_ff[1] |=> !pend_ff[1])
    else $error("pin 26 pending set while disabled");
  a_clear_pend: assert property (clr[1] && !evt[1] |=> !pend_ff[1])
    else $error("pending not cleared");

  c_pend_set: cover property ($rose(pend_ff[0]));
  c_fwd_req: cover property ($rose(INTERRUPT_CONTROLLER_REQ_O[1]));
  c_irq_clear: cover property (IRQ_O ##1 WR_I && ADDR_I == OFF_IRQ_CLEAR ##1 !IRQ_O);
  c_analog: cover property ($rose(ADC10_SEL_O));
  c_level_hold: cover property (clr[0] && evt[0] ##1 pend_ff[0]);

endmodule : pcim_top

/* verification/pcim_pin_model.sv */
// pcim_pin_model: pad-side stand-in that moves the levels on pins 25 and 26.
// assumes the bench asks for levels; the pads follow a few ns later, off the clock edge.
`timescale 1ns/10ps
module pcim_pin_model (
  // requested levels
  input  wire logic [1:0] lvl_i,
  // pad levels toward the block
  output wire logic [1:0] pin_o
);
  // the pads settle away from CLK_I, so the block has to synchronise them
  assign #7 pin_o = lvl_i;
endmodule : pcim_pin_model

/* verification/pcim_top_test.sv */
// pcim_top_test: self-checking bench for the pin control and interrupt mux.
// assumes pcim_pkg and pcim_top; pins are moved through pcim_pin_model.
`timescale 1ns/10ps
module pcim_top_test;
  import pcim_pkg::*;
  // one trigger case: pin, mode, enable, mask, start and end level, pending wanted
  typedef struct packed {
    logic       pin;
    logic [2:0] trig;
    logic       en;
    logic       mask;
    logic       from;
    logic       to;
    logic       exp;
  } pcim_row_t;
  localparam pcim_row_t ROWS [15] = '{
    '{1'b0, TRIG_RISE, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1}, '{1'b0, TRIG_RISE, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0},
    '{1'b0, TRIG_FALL, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1}, '{1'b0, TRIG_FALL, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0},
    '{1'b0, TRIG_BOTH, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1}, '{1'b0, TRIG_BOTH, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1},
    '{1'b0, TRIG_HIGH, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1}, '{1'b0, TRIG_LOW, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1},
    '{1'b0, 3'h5, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0}, '{1'b0, 3'h6, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0},
    '{1'b0, 3'h7, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0}, '{1'b0, TRIG_RISE, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
    '{1'b0, TRIG_RISE, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1}, '{1'b1, TRIG_FALL, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1},
    '{1'b1, TRIG_HIGH, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1}};
  // design side signals
  logic        clk;
  logic        rst_b;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [1:0]  lvl;
  wire  [1:0]  pin;
  pcim_pad_t   pad25;
  pcim_pad_t   pad26;
  pcim_pad_t   pad38;
  logic [3:0]  f25;
  logic [3:0]  f26;
  logic        adc9;
  logic        adc10;
  logic        vref;
  logic [1:0]  pend;
  logic [1:0]  req;
  logic        irq;
  // bookkeeping
  int          err_total;
  int          total_checks;
  logic [31:0] rv;
  pcim_row_t   r;

  pcim_pin_model pads (.lvl_i(lvl), .pin_o(pin));
  pcim_top dut (
    .CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RD_DATA_O(rdata), .PIN_I(pin), .PAD25_O(pad25), .PAD26_O(pad26), .PAD38_O(pad38),
    .FUNC25_SEL_O(f25), .FUNC26_SEL_O(f26), .ADC9_SEL_O(adc9), .ADC10_SEL_O(adc10),
    .VREF_OUT_EN_O(vref), .PEND_O(pend), .INTERRUPT_CONTROLLER_REQ_O(req), .IRQ_O(irq));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // compare one value, count and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // counts, verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // watchdog well beyond the expected run of about 350 cycles
  initial begin
    #(25 * 5000);
    err_total++;
    print_verdict();
  end

  initial begin
    clk = 1'b0; rst_b = 1'b0; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0; lvl = 2'b00;
    err_total = 0; total_checks = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // reset values
    rd_reg(OFF_PIN25_CTL, rv); chk(rv, RST_TRIG_PIN);
    rd_reg(OFF_PIN26_CTL, rv); chk(rv, RST_TRIG_PIN);
    rd_reg(OFF_PIN38_CTL, rv); chk(rv, RST_PIN38);
    chk({vref, f25, f26, pad25}, {1'b1, FN_PLAIN, FN_PLAIN, DRV_RST, 8'h00});
    chk({pend, req, irq}, 5'h00);
    $display("test reset values done");
    // trigger table: arm, settle, clear, move the pin, look at pending
    foreach (ROWS[i]) begin
      r = ROWS[i];
      @(posedge clk);
      lvl[r.pin] <= r.from;
      wr_reg(OFF_PIN25_CTL + {9'h000, r.pin, 2'h0}, {6'h00, r.mask, 1'b0, r.trig, r.en, 20'h01001});
      repeat (4) @(posedge clk);
      wr_reg(OFF_IRQ_CLEAR, 32'h0000_0003);
      lvl[r.pin] <= r.to;
      repeat (5) @(posedge clk);
      #1 chk(pend[r.pin], r.exp);
      chk(req[r.pin], r.exp & r.mask & r.en);
      chk(irq, 32'h0000_0000);
    end
    $display("test trigger table done");
    // reserved bits, unmapped place, pad fields; distinct channels per pin
    wr_reg(OFF_PIN25_CTL, 32'hFFFF_FFFF); rd_reg(OFF_PIN25_CTL, rv); chk(rv, MASK_TRIG_PIN);
    wr_reg(OFF_PIN38_CTL, 32'hFFFF_FFFF); rd_reg(OFF_PIN38_CTL, rv); chk(rv, MASK_PIN38);
    wr_reg(12'h200, 32'hFFFF_FFFF); rd_reg(12'h200, rv); chk(rv, 32'h0000_0000);
    @(posedge clk); #1 chk(rdata, 32'h0000_0000);
    wr_reg(OFF_PIN25_CTL, 32'h0000_5BF0); wr_reg(OFF_PIN26_CTL, 32'h0000_5BF0);
    wr_reg(OFF_PIN38_CTL, 32'h0000_5BE0); rd_reg(OFF_PIN38_CTL, rv); chk(rv, 32'h0000_53C0);
    chk({pad25, adc9, f25}, {11'h5EF, 1'b1, FN_LCD_SEG});
    chk({pad26, adc10}, {11'h5DF, 1'b1});
    chk({pad38, vref}, {11'h55C, 1'b0});
    $display("test pad fields done");
    // every function code on both pins
    for (int c = 0; c < 16; c++) begin
      wr_reg(OFF_PIN25_CTL, {28'h0000100, c[3:0]});
      wr_reg(OFF_PIN26_CTL, {28'h0000100, c[3:0]});
      #1 chk(f25, (c <= 8) ? c[3:0] : FN_PLAIN);
      chk(f26, (c <= 8 && c != 6) ? c[3:0] : FN_PLAIN);
    end
    $display("test function codes done");
    // status, enable and clear registers with the level output
    @(posedge clk); lvl <= 2'b00;
    wr_reg(OFF_PIN25_CTL, 32'h0210_1001); wr_reg(OFF_PIN26_CTL, 32'h0010_1001);
    repeat (4) @(posedge clk);
    wr_reg(OFF_IRQ_CLEAR, 32'h0000_0003);
    lvl <= 2'b11;
    repeat (5) @(posedge clk);
    #1 chk({pend, req, irq}, 5'b11_01_0);
    wr_reg(OFF_IRQ_STATUS, 32'h0000_0000);
    rd_reg(OFF_IRQ_STATUS, rv); chk(rv, 32'h0000_0003);
    wr_reg(OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
    rd_reg(OFF_IRQ_ENABLE, rv); chk({rv[30:0], irq}, 32'h0000_0007);
    wr_reg(OFF_IRQ_ENABLE, 32'h0000_0002); wr_reg(OFF_IRQ_CLEAR, 32'h0000_0002);
    #1 chk({pend, irq}, 3'b01_0);
    rd_reg(OFF_IRQ_CLEAR, rv); chk(rv, 32'h0000_0000);
    // a held level keeps pending set through a clear, since set wins over clear
    wr_reg(OFF_PIN25_CTL, 32'h0270_1001);
    wr_reg(OFF_IRQ_CLEAR, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1 chk(pend[0], 32'h0000_0001);
    $display("test interrupt registers done");
    // reset again in mid-run
    @(posedge clk); rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(OFF_PIN25_CTL, rv); chk(rv, RST_TRIG_PIN); chk({pend, vref}, 3'b001);
    $display("test second reset done");
    print_verdict();
  end
endmodule : pcim_top_test
